/* common/ohr_map.svh */
// Summary of operation
// - A write to a read-only register leaves it unchanged unless that register defines a side effect.
// - A write to the most significant byte address of a counter buffers it and restarts the counter.
// - A read of a write-only register returns an arbitrary value, here zero.
// - A read/write register accepts writes and returns the stored value on reads.
// - At reset every register loads a fixed default giving minimal working function.
// - A write to the global snapshot address buffers every performance counter at once.
// - Loss of frame uses L, M and N parameters held in a two-byte read/write register pair.
// - The excess parity state sets after a set count of consecutive windows above a set threshold.
// - The excess parity state clears after a clear count of windows at or below a clear threshold.
// - The parity bit error and remote bit error counters are 24-bit read-only over three bytes.
// - The parity block and remote block error counters are 16-bit read-only over two bytes.
// - Out-of-frame event and section parity error counters are 16-bit read-only over two bytes.
// - A counter is read by buffering it, singly or all at once, then reading buffer bytes.
`ifndef OHR_MAP_SVH
`define OHR_MAP_SVH
`define OHR_A_APS1 8'h00
`define OHR_A_NAT_C 8'h05
`define OHR_A_REI_BLK 8'h09
`define OHR_A_REI_BIP 8'h0B
`define OHR_A_TR_CTRL 8'h0E
`define OHR_A_TR_DATA 8'h0F
`define OHR_A_B2_BLK 8'h10
`define OHR_A_B2_BIP 8'h12
`define OHR_A_CLR_WIN 8'h15
`define OHR_A_CLR_CNT 8'h17
`define OHR_A_CLR_THR 8'h18
`define OHR_A_SET_WIN 8'h1B
`define OHR_A_SET_CNT 8'h1D
`define OHR_A_SET_THR 8'h1E
`define OHR_A_CFG1 8'h40
`define OHR_A_LMN 8'h41
`define OHR_A_OOF 8'h43
`define OHR_A_B1 8'h45
`define OHR_A_CFG2 8'h47
`define OHR_A_OP1 8'h50
`define OHR_A_OP2 8'h51
`define OHR_A_ID 8'h52
`define OHR_A_SNAP 8'h54
`define OHR_RST_WIN 16'h0008
`define OHR_RST_CNT 8'h03
`define OHR_RST_SET_THR 8'h04
`define OHR_RST_CLR_THR 8'h01
`define OHR_RST_LMN 16'h3818
`define OHR_RST_CFG 8'h00
`define OHR_DEVICE_IDENTIFIER 8'h5A
`endif

/* common/ohr_pkg.sv */
package ohr_pkg;
   // Microprocessor pins as seen at the device.
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [7:0] addr;
      logic [7:0] data;
   } ohr_bus_s;
   // Events from the overhead datapath, one-cycle pulses.
   typedef struct packed {
      logic frame;
      logic oof;
      logic b1;
      logic b2_blk;
      logic b2_bip;
      logic rei_blk;
      logic rei_bip;
   } ohr_evt_s;
   // Counter address decode result.
   typedef struct packed {
      logic hit;
      logic msb;
      logic [2:0] idx;
      logic [1:0] byt;
   } ohr_hit_s;
   typedef enum logic [1:0] {
      OHR_WATCH_SET = 2'b01,
      OHR_WATCH_CLR = 2'b10
   } ohr_xs_e;
   typedef logic [5:0][7:0] ohr_rxbytes_t;
endpackage

/* hdl/ohr_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ohr_map.svh"
module ohr_regs #(
   parameter logic [7:0] DEVICE_IDENTIFIER = `OHR_DEVICE_IDENTIFIER
) (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // Microprocessor pins.
   input wire ohr_pkg::ohr_bus_s i_bus,
   output logic [7:0] o_data,
   output logic o_data_oe_n,
   // Datapath events and received bytes.
   input wire ohr_pkg::ohr_evt_s i_evt,
   input wire ohr_pkg::ohr_rxbytes_t i_rx_bytes,
   // Configuration and state toward the datapath.
   output logic [15:0] o_frame_loss_params,
   output logic [7:0] o_rx_regen_config_one,
   output logic [7:0] o_rx_regen_config_two,
   output logic [7:0] o_operational_config_one,
   output logic [7:0] o_operational_config_two,
   output logic [7:0] o_trace_ctrl,
   output logic [7:0] o_trace_data,
   output logic o_excess_parity_error_state,
   output logic [5:0] o_cnt_overflow
);
   import ohr_pkg::*;

   localparam int NC = 6;
   localparam logic [NC-1:0] WIDE = 6'b10_1000;

   typedef struct packed {
      ohr_bus_s sync1;
      ohr_bus_s sync2;
      logic wr_prev;
      logic [7:0] rd_data;
      logic oe_n;
      ohr_rxbytes_t rx;
      logic [NC-1:0][23:0] cnt;
      logic [NC-1:0][23:0] bufr;
      logic [NC-1:0] ovf;
      logic [7:0] tr_ctrl;
      logic [7:0] tr_data;
      logic [15:0] clr_win;
      logic [7:0] clr_cnt;
      logic [7:0] clr_thr;
      logic [15:0] set_win;
      logic [7:0] set_cnt;
      logic [7:0] set_thr;
      logic [7:0] cfg1;
      logic [15:0] lmn;
      logic [7:0] cfg2;
      logic [7:0] op1;
      logic [7:0] op2;
      ohr_xs_e xs;
      logic [15:0] win_pos;
      logic [15:0] win_errs;
      logic [7:0] consec;
   } ohr_state_s;

   ohr_state_s st_q;
   ohr_state_s st_d;

   // Counters: 0 out-of-frame, 1 section parity, 2 parity block, 3 parity bit,
   // 4 remote block, 5 remote bit. Base is the least significant byte.
   function automatic ohr_hit_s cnt_decode(input logic [7:0] a);
      ohr_hit_s h;
      logic [7:0] base;
      h = '0;
      for (int i = 0; i < NC; i++)
      begin
         unique case (i)
            0: base = `OHR_A_OOF;
            1: base = `OHR_A_B1;
            2: base = `OHR_A_B2_BLK;
            3: base = `OHR_A_B2_BIP;
            4: base = `OHR_A_REI_BLK;
            default: base = `OHR_A_REI_BIP;
         endcase
         if (a == base || a == base + 8'h01 || (WIDE[i] && a == base + 8'h02))
         begin
            h.hit = 1'b1;
            h.idx = 3'(i);
            h.byt = 2'(a - base);
            h.msb = (a == base + (WIDE[i] ? 8'h02 : 8'h01));
         end
      end
      return h;
   endfunction

   logic wr_stb;
   logic rd_act;
   ohr_hit_s wh;
   ohr_hit_s rh;
   logic [NC-1:0] inc;
   logic [NC-1:0] snap;
   logic [15:0] errs_now;
   logic win_end;
   logic [15:0] win_size;

   // Pin samples pass two flip-flops; a write is taken when the strobe rises,
   // because the data is certain to be stable by then.
   always_comb
   begin
      wr_stb = !st_q.sync2.cs_n && st_q.sync2.wr_n && !st_q.wr_prev && st_q.sync2.rd_n;
      rd_act = !st_q.sync2.cs_n && !st_q.sync2.rd_n && st_q.sync2.wr_n;
      wh = cnt_decode(st_q.sync2.addr);
      rh = wh;
      inc = {i_evt.rei_bip, i_evt.rei_blk, i_evt.b2_bip, i_evt.b2_blk, i_evt.b1, i_evt.oof};
      for (int i = 0; i < NC; i++)
      begin
         snap[i] = wr_stb && (st_q.sync2.addr == `OHR_A_SNAP ||
            (wh.hit && wh.msb && wh.idx == 3'(i)));
      end
   end

   // Window bookkeeping for the excess parity error state. The active window
   // size follows the present state, so set and clear use separate figures.
   always_comb
   begin
      win_size = (st_q.xs == OHR_WATCH_SET) ? st_q.set_win : st_q.clr_win;
      errs_now = st_q.win_errs + {15'h0000, i_evt.b2_bip};
      if (errs_now < st_q.win_errs)
      begin
         errs_now = 16'hFFFF;
      end
      win_end = i_evt.frame && (st_q.win_pos + 16'h0001 >= win_size);
   end

   // Next-state logic for the whole register bank.
   always_comb
   begin
      st_d = st_q;
      st_d.sync1 = i_bus;
      st_d.sync2 = st_q.sync1;
      st_d.wr_prev = st_q.sync2.wr_n;
      st_d.rx = i_rx_bytes;
      st_d.oe_n = !rd_act;
      // Counters saturate rather than wrap so a heavy burst never reads small.
      for (int i = 0; i < NC; i++)
      begin
         if (snap[i])
         begin
            st_d.bufr[i] = st_q.cnt[i];
            st_d.cnt[i] = {23'h00_0000, inc[i]};
            st_d.ovf[i] = 1'b0;
         end
         else if (inc[i])
         begin
            if (st_q.cnt[i] == (WIDE[i] ? 24'hFF_FFFF : 24'h00_FFFF))
            begin
               st_d.ovf[i] = 1'b1;
            end
            else
            begin
               st_d.cnt[i] = st_q.cnt[i] + 24'h00_0001;
            end
         end
      end
      // Register writes; read-only and unmapped addresses fall through.
      if (wr_stb)
      begin
         unique case (st_q.sync2.addr)
            `OHR_A_TR_CTRL: st_d.tr_ctrl = st_q.sync2.data;
            `OHR_A_TR_DATA: st_d.tr_data = st_q.sync2.data;
            `OHR_A_CLR_WIN: st_d.clr_win[7:0] = st_q.sync2.data;
            `OHR_A_CLR_WIN + 8'h01: st_d.clr_win[15:8] = st_q.sync2.data;
            `OHR_A_CLR_CNT: st_d.clr_cnt = st_q.sync2.data;
            `OHR_A_CLR_THR: st_d.clr_thr = st_q.sync2.data;
            `OHR_A_SET_WIN: st_d.set_win[7:0] = st_q.sync2.data;
            `OHR_A_SET_WIN + 8'h01: st_d.set_win[15:8] = st_q.sync2.data;
            `OHR_A_SET_CNT: st_d.set_cnt = st_q.sync2.data;
            `OHR_A_SET_THR: st_d.set_thr = st_q.sync2.data;
            `OHR_A_CFG1: st_d.cfg1 = st_q.sync2.data;
            `OHR_A_LMN: st_d.lmn[7:0] = st_q.sync2.data;
            `OHR_A_LMN + 8'h01: st_d.lmn[15:8] = st_q.sync2.data;
            `OHR_A_CFG2: st_d.cfg2 = st_q.sync2.data;
            `OHR_A_OP1: st_d.op1 = st_q.sync2.data;
            `OHR_A_OP2: st_d.op2 = st_q.sync2.data;
            default: st_d.op2 = st_q.op2;
         endcase
      end
      // Read mux; the snapshot address is write-only and reads as zero.
      st_d.rd_data = 8'h00;
      if (rh.hit)
      begin
         st_d.rd_data = st_q.bufr[rh.idx][8*rh.byt +: 8];
      end
      else if (st_q.sync2.addr >= `OHR_A_APS1 && st_q.sync2.addr <= `OHR_A_NAT_C)
      begin
         st_d.rd_data = st_q.rx[st_q.sync2.addr[2:0]];
      end
      else
      begin
         unique case (st_q.sync2.addr)
            `OHR_A_TR_CTRL: st_d.rd_data = st_q.tr_ctrl;
            `OHR_A_TR_DATA: st_d.rd_data = st_q.tr_data;
            `OHR_A_CLR_WIN: st_d.rd_data = st_q.clr_win[7:0];
            `OHR_A_CLR_WIN + 8'h01: st_d.rd_data = st_q.clr_win[15:8];
            `OHR_A_CLR_CNT: st_d.rd_data = st_q.clr_cnt;
            `OHR_A_CLR_THR: st_d.rd_data = st_q.clr_thr;
            `OHR_A_SET_WIN: st_d.rd_data = st_q.set_win[7:0];
            `OHR_A_SET_WIN + 8'h01: st_d.rd_data = st_q.set_win[15:8];
            `OHR_A_SET_CNT: st_d.rd_data = st_q.set_cnt;
            `OHR_A_SET_THR: st_d.rd_data = st_q.set_thr;
            `OHR_A_CFG1: st_d.rd_data = st_q.cfg1;
            `OHR_A_LMN: st_d.rd_data = st_q.lmn[7:0];
            `OHR_A_LMN + 8'h01: st_d.rd_data = st_q.lmn[15:8];
            `OHR_A_CFG2: st_d.rd_data = st_q.cfg2;
            `OHR_A_OP1: st_d.rd_data = st_q.op1;
            `OHR_A_OP2: st_d.rd_data = st_q.op2;
            `OHR_A_ID: st_d.rd_data = DEVICE_IDENTIFIER;
            default: st_d.rd_data = 8'h00;
         endcase
      end
      // Excess parity window machine. The error count of a window includes an
      // error arriving on the closing frame itself.
      if (i_evt.frame)
      begin
         st_d.win_pos = st_q.win_pos + 16'h0001;
      end
      st_d.win_errs = errs_now;
      if (win_end)
      begin
         st_d.win_pos = 16'h0000;
         st_d.win_errs = 16'h0000;
         unique case (st_q.xs)
            OHR_WATCH_SET:
            begin
               if (errs_now > {8'h00, st_q.set_thr})
               begin
                  st_d.consec = st_q.consec + 8'h01;
                  if (st_q.consec + 8'h01 >= st_q.set_cnt)
                  begin
                     st_d.xs = OHR_WATCH_CLR;
                     st_d.consec = 8'h00;
                  end
               end
               else
               begin
                  st_d.consec = 8'h00;
               end
            end
            OHR_WATCH_CLR:
            begin
               if (errs_now <= {8'h00, st_q.clr_thr})
               begin
                  st_d.consec = st_q.consec + 8'h01;
                  if (st_q.consec + 8'h01 >= st_q.clr_cnt)
                  begin
                     st_d.xs = OHR_WATCH_SET;
                     st_d.consec = 8'h00;
                  end
               end
               else
               begin
                  st_d.consec = 8'h00;
               end
            end
            default: st_d.xs = OHR_WATCH_SET;
         endcase
      end
   end

   // State register; reset loads constants only.
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st_q <= '0;
         st_q.sync1 <= 19'h7_FF00;
         st_q.sync2 <= 19'h7_FF00;
         st_q.wr_prev <= 1'b1;
         st_q.oe_n <= 1'b1;
         st_q.clr_win <= `OHR_RST_WIN;
         st_q.clr_cnt <= `OHR_RST_CNT;
         st_q.clr_thr <= `OHR_RST_CLR_THR;
         st_q.set_win <= `OHR_RST_WIN;
         st_q.set_cnt <= `OHR_RST_CNT;
         st_q.set_thr <= `OHR_RST_SET_THR;
         st_q.lmn <= `OHR_RST_LMN;
         st_q.cfg1 <= `OHR_RST_CFG;
         st_q.cfg2 <= `OHR_RST_CFG;
         st_q.op1 <= `OHR_RST_CFG;
         st_q.op2 <= `OHR_RST_CFG;
         st_q.xs <= OHR_WATCH_SET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flip-flops, except the excess parity state, which is decoded from st_q.xs.
   assign o_data = st_q.rd_data;
   assign o_data_oe_n = st_q.oe_n;
   assign o_frame_loss_params = st_q.lmn;
   assign o_rx_regen_config_one = st_q.cfg1;
   assign o_rx_regen_config_two = st_q.cfg2;
   assign o_operational_config_one = st_q.op1;
   assign o_operational_config_two = st_q.op2;
   assign o_trace_ctrl = st_q.tr_ctrl;
   assign o_trace_data = st_q.tr_data;
   assign o_excess_parity_error_state = (st_q.xs == OHR_WATCH_CLR);
   assign o_cnt_overflow = st_q.ovf;

   // Helper: marks the first cycle after reset release.
   logic seen_q;
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         seen_q <= 1'b0;
      end
      else
      begin
         seen_q <= 1'b1;
      end
   end

   sequence s_set_close;
      win_end && st_q.xs == OHR_WATCH_SET && errs_now > {8'h00, st_q.set_thr}
         && st_q.consec + 8'h01 >= st_q.set_cnt;
   endsequence

   sequence s_clr_close;
      win_end && st_q.xs == OHR_WATCH_CLR && errs_now <= {8'h00, st_q.clr_thr}
         && st_q.consec + 8'h01 >= st_q.clr_cnt;
   endsequence

   chk_ro_write_kept: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      wr_stb && st_q.sync2.addr == `OHR_A_OOF |=> $stable(st_q.bufr[0]))
      else $error("Write to a counter low byte changed its buffer.");
   chk_msb_snap_one: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      wr_stb && st_q.sync2.addr == `OHR_A_B1 + 8'h01 |=>
         st_q.bufr[1] == $past(st_q.cnt[1]) && st_q.cnt[1] <= 24'h00_0001)
      else $error("Write to counter top byte did not buffer and restart it.");
   chk_wo_read_zero: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      st_q.sync2.addr == `OHR_A_SNAP |=> st_q.rd_data == 8'h00)
      else $error("Snapshot address read returned nonzero.");
   chk_rw_readback: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      wr_stb && st_q.sync2.addr == `OHR_A_OP1 ##1 st_q.sync2.addr == `OHR_A_OP1
         |=> st_q.rd_data == $past(st_q.sync2.data, 2))
      else $error("Read/write register did not return the written value.");
   chk_reset_default: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      !seen_q |-> st_q.lmn == `OHR_RST_LMN && st_q.xs == OHR_WATCH_SET && st_q.oe_n)
      else $error("Register did not hold its default after reset.");
   chk_snap_all: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      wr_stb && st_q.sync2.addr == `OHR_A_SNAP |=>
         st_q.bufr == $past(st_q.cnt) && st_q.ovf == 6'h00)
      else $error("Global snapshot did not buffer every counter.");
   chk_lmn_write: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      wr_stb && st_q.sync2.addr == `OHR_A_LMN + 8'h01 |=>
         o_frame_loss_params[15:8] == $past(st_q.sync2.data))
      else $error("Frame loss parameter upper byte not written.");
   chk_excess_set: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      s_set_close |=> o_excess_parity_error_state)
      else $error("Excess parity state failed to set.");
   chk_excess_clear: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      s_clr_close |=> !o_excess_parity_error_state)
      else $error("Excess parity state failed to clear.");
   chk_excess_hold: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      !win_end |=> $stable(o_excess_parity_error_state))
      else $error("Excess parity state moved outside a window close.");
   chk_narrow_width: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      st_q.cnt[0][23:16] == 8'h00 && st_q.cnt[4][23:16] == 8'h00)
      else $error("Sixteen-bit counter exceeded its width.");
   chk_sat_flag: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      inc[3] && !snap[3] && st_q.cnt[3] == 24'hFF_FFFF |=>
         st_q.ovf[3] && st_q.cnt[3] == 24'hFF_FFFF)
      else $error("Wide counter did not saturate with overflow.");
   chk_read_drive: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      !i_bus.cs_n && !i_bus.rd_n && i_bus.wr_n [*3] |-> ##[0:1] !o_data_oe_n)
      else $error("Data bus not driven during a read.");
endmodule
`default_nettype wire

/* verification/ohr_host.sv */
`timescale 1ns/1ns
`default_nettype none
module ohr_host (
   // Clock.
   input wire logic i_ref_clk,
   // Pins toward the device.
   output var ohr_pkg::ohr_bus_s o_bus,
   input wire logic [7:0] i_data,
   input wire logic i_data_oe_n,
   // Read results, one cycle each.
   output var logic o_rd_vld,
   output var logic [7:0] o_rd_data
);
   import ohr_pkg::*;
   // No bits are reserved here, so the read mask keeps all of them.
   localparam logic [7:0] MASK = 8'hFF;
   // Strobes idle high after reset; the data lines start at zero.
   initial
   begin
      o_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, data: 8'h00};
      o_rd_vld = 1'b0;
      o_rd_data = 8'h00;
   end
   // Bus levels are held four clocks, past the two-flop synchroniser.
   task automatic hold(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask
   // Write cycle; every bit is written, so no reserved bit is left to chance.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      o_bus.cs_n = 1'b0;
      o_bus.addr = a;
      o_bus.data = d;
      o_bus.wr_n = 1'b0;
      hold(4);
      o_bus.wr_n = 1'b1;
      hold(4);
      o_bus.cs_n = 1'b1;
      o_bus.data = ~d;
      hold(4);
   endtask
   // Read cycle; a released bus shows the inverse of its last value.
   task automatic rd(input logic [7:0] a);
      o_bus.cs_n = 1'b0;
      o_bus.addr = a;
      o_bus.data = ~o_bus.data;
      o_bus.rd_n = 1'b0;
      hold(4);
      o_rd_data = (i_data_oe_n === 1'b0) ? (i_data & MASK) : 8'hxx;
      o_rd_vld = 1'b1;
      o_bus.rd_n = 1'b1;
      hold(1);
      o_rd_vld = 1'b0;
      o_bus.cs_n = 1'b1;
      hold(4);
   endtask
endmodule
`default_nettype wire

/* verification/sdh_overhead_register_map_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module sdh_overhead_register_map_tb_top;
   import ohr_pkg::*;
   localparam logic [7:0] RA [16] = '{8'h41, 8'h42, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1B,
      8'h1C, 8'h1D, 8'h1E, 8'h40, 8'h47, 8'h50, 8'h51, 8'h0E, 8'h0F};
   localparam logic [7:0] RV [16] = '{8'h18, 8'h38, 8'h08, 8'h00, 8'h03, 8'h01, 8'h08,
      8'h00, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] XV [8] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h02, 8'h01};
   localparam logic [7:0] CB [6] = '{8'h43, 8'h45, 8'h10, 8'h12, 8'h09, 8'h0B};
   localparam int CN [6] = '{2, 2, 2, 3, 2, 3};
   logic i_ref_clk = 1'b0;
   logic i_arst_n = 1'b0;
   ohr_bus_s hb;
   ohr_bus_s bus_w;
   ohr_evt_s evt = '0;
   ohr_rxbytes_t rxb = '0;
   logic [7:0] o_data, rd_data, c1, c2, op1, op2, tc, td;
   logic oe_n, rd_vld, xs;
   logic [15:0] lmn, note;
   logic [5:0] ovf;
   logic [7:0] wv [16];
   logic [7:0] n [6];
   logic [15:0] exp_q [$];
   int fail_count = 0;
   int compares = 0;
   int seed = 32'h12057ba7;
   // The data wire carries the device while it drives, else the host.
   always_comb
   begin
      bus_w = hb;
      if (oe_n === 1'b0)
         bus_w.data = o_data;
   end
   always #50 i_ref_clk = ~i_ref_clk;
   ohr_host host_u (.i_ref_clk(i_ref_clk), .o_bus(hb), .i_data(bus_w.data),
      .i_data_oe_n(oe_n), .o_rd_vld(rd_vld), .o_rd_data(rd_data));
   ohr_regs dut_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_bus(bus_w),
      .o_data(o_data), .o_data_oe_n(oe_n), .i_evt(evt), .i_rx_bytes(rxb),
      .o_frame_loss_params(lmn), .o_rx_regen_config_one(c1), .o_rx_regen_config_two(c2),
      .o_operational_config_one(op1), .o_operational_config_two(op2), .o_trace_ctrl(tc),
      .o_trace_data(td), .o_excess_parity_error_state(xs), .o_cnt_overflow(ovf));
   task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // The expectation is queued before the cycle starts, so the monitor never waits on it.
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({a, e});
      host_u.rd(a);
   endtask
   // Top byte first, which the buffer must allow.
   task automatic rd_cnt(input int i, input logic [23:0] v);
      for (int b = CN[i] - 1; b >= 0; b--)
         rd_exp(CB[i] + 8'(b), v[8 * b +: 8]);
   endtask
   // Counter i gets n[i] pulses, all counters in the same cycles.
   task automatic burst();
      for (int j = 0; j < 8; j++)
      begin
         for (int i = 0; i < 6; i++)
            evt[5 - i] = (j < int'(n[i]));
         @(negedge i_ref_clk);
      end
      evt = '0;
   endtask
   task automatic pulse(input logic [6:0] m);
      evt = ohr_evt_s'(m);
      @(negedge i_ref_clk);
      evt = '0;
   endtask
   // One window of size one: e parity errors, then the closing frame.
   task automatic win(input int e);
      repeat (e) pulse(7'h04);
      pulse(7'h40);
      repeat (3) @(negedge i_ref_clk);
   endtask
   // Each read result retires the oldest expected value.
   always @(posedge i_ref_clk)
   begin
      if (rd_vld === 1'b1)
      begin
         note = exp_q.pop_front();
         check($sformatf("reg %h", note[15:8]), rd_data, note[7:0]);
      end
   end
   // A hang costs far more than the roughly 1200 cycles the sequence needs.
   initial
   begin
      #5_000_000;
      fail_count++;
      results();
   end
   initial
   begin
      repeat (6) @(negedge i_ref_clk);
      i_arst_n = 1'b1;
      repeat (2) @(negedge i_ref_clk);
      for (int i = 0; i < 6; i++)
         rxb[i] = 8'($random(seed));
      for (int i = 0; i < 16; i++)
         rd_exp(RA[i], RV[i]);
      rd_exp(8'h52, 8'h5A);
      rd_cnt(0, 24'h0);
      check("lmn", lmn, 16'h3818);
      check("state", {xs, ovf}, 7'h00);
      for (int i = 0; i < 16; i++)
      begin
         wv[i] = 8'($random(seed));
         host_u.wr(RA[i], wv[i]);
      end
      for (int i = 0; i < 16; i++)
         rd_exp(RA[i], wv[i]);
      check("lmn", lmn, {wv[1], wv[0]});
      check("cfg", {c1, c2, op1, op2, tc, td}, {wv[10], wv[11], wv[12], wv[13], wv[14], wv[15]});
      for (int i = 0; i < 6; i++)
      begin
         host_u.wr(8'(i), ~rxb[i]);
         rd_exp(8'(i), rxb[i]);
      end
      host_u.wr(8'h52, 8'hA5);
      rd_exp(8'h52, 8'h5A);
      rd_exp(8'h54, 8'h00);
      rd_exp(8'h60, 8'h00);
      for (int i = 0; i < 6; i++)
         n[i] = 8'(1 + ($random(seed) & 7));
      burst();
      for (int i = 0; i < 6; i++)
         host_u.wr(CB[i] + 8'(CN[i] - 1), 8'h00);
      for (int i = 0; i < 6; i++)
         rd_cnt(i, 24'(n[i]));
      for (int i = 0; i < 6; i++)
         n[i] = 8'(1 + ($random(seed) & 7));
      burst();
      host_u.wr(8'h54, 8'h00);
      for (int i = 0; i < 6; i++)
         rd_cnt(i, 24'(n[i]));
      check("ovf", ovf, 6'h00);
      for (int i = 0; i < 8; i++)
         host_u.wr(RA[i + 2], XV[i]);
      win(0);
      win(1);
      win(2);
      check("xs", xs, 1'b0);
      win(2);
      check("xs", xs, 1'b1);
      win(0);
      win(1);
      win(0);
      check("xs", xs, 1'b1);
      win(0);
      check("xs", xs, 1'b0);
      results();
   end
endmodule
`default_nettype wire
